// >>> core/pwm_mode_pkg.sv
// constants and types for the dual pwm mode and phase selector
// assumes one system clock; strap comparators live outside this logic
package pwm_mode_pkg;
   // oscillator cycle is cut into 360 phase steps, one per clock
   localparam int PHASE_W = 9;
   localparam logic [8:0] CYCLE_STEPS = 9'h168; // 360 steps
   localparam logic [8:0] PH_0   = 9'h000;
   localparam logic [8:0] PH_60  = 9'h03c;
   localparam logic [8:0] PH_90  = 9'h05a;
   localparam logic [8:0] PH_120 = 9'h078;
   localparam logic [8:0] PH_180 = 9'h0b4;
   localparam logic [8:0] PH_240 = 9'h0f0;
   localparam logic [8:0] PH_300 = 9'h12c; // ch1 60 deg behind ch2
   // clocks a strap set must stay stable before it is accepted
   localparam logic [3:0] STRAP_SETTLE = 4'h8;
   // reference window codes from the external level comparators
   typedef enum logic [1:0] {
      REF_LOW, REF_MID_LO, REF_MID_HI, REF_HIGH
   } ref_level_type;
   typedef enum logic [3:0] {
      M_DISABLED, M_SINGLE, M_DUAL_0, M_DUAL_90, M_DUAL_180,
      M_DDR, M_TWO_PHASE, M_THREE_PHASE, M_FOUR_PHASE
   } mode_type;
endpackage

// >>> core/dual_pwm_mode_phase_select.sv
// mode decoder and phase interleave selector for a dual buck controller
// assumes strap comparator results synchronous to clk_sys
//
// Behaviour
// R1: ch near-supply negative sense disables its error and diff amps (tristate).
// R2: both enables low means fully disabled, no switching. Here ch1Run and ch2Run stay low, but ch1Clock and ch2Clock keep toggling.
// R3: one enable high runs single phase; share carries ch1 current plus offset.
// R4: dual mode ch2 delay 0, 90 or 180 deg from reference level.
// R5: ddr mode ch2 reference is lowest of 0.6V, external, soft-start.
// R6: ddr mode channel 1 lags channel 2 by 60 deg.
// R7: ch2 sense high, feedback low: two phase, channels 180 deg apart.
// R8: two phase mode emits sync clock rising 60 deg after ch1.
// R9: sense high, feedback high, pos sense low: channels 240 deg apart.
// R10: three phase mode emits sync clock 120 deg after ch1.
// R11: all high: channels 180 apart, sync clock rising 90 deg after ch1.
// R12: a partner on the 90 deg clock runs dual, ddr, two or four phase.
// R13: twelve phases reachable by cascading sync clocks, no external clock.
// R14: other phase counts need an external clock from outside.
// R15: dual modes disable sync clock; pin is reference input only.
// R16: decode straps before switching; all phases from one oscillator cycle.
`timescale 1ns/1ps
`default_nettype none
module dual_pwm_mode_phase_select
   import pwm_mode_pkg::*;
(
   // clock and reset
   input  wire logic                         clk_sys,
   input  wire logic                         sys_rst,
   // strap levels, already compared
   input  wire logic                         ch1EnableFeedforward,
   input  wire logic                         ch2EnableFeedforward,
   input  wire logic                         ch1NegSenseStrap,
   input  wire logic                         ch2NegSenseStrap,
   input  wire logic                         ch2FeedbackStrap,
   input  wire logic                         ch2PosSenseStrap,
   input  wire pwm_mode_pkg::ref_level_type  refLevel,
   // reference selection inputs for channel 2
   input  wire logic                         extRefBelowInt,
   input  wire logic                         softStartBelowExt,
   input  wire logic                         softStartBelowInt,
   // decoded mode and controls
   output logic                              modeValid,
   output pwm_mode_pkg::mode_type            mode,
   output logic                              ch1AmpEnable,
   output logic                              ch2AmpEnable,
   output logic                              shareCh1Only,
   output logic [1:0]                        ch2RefSelect,
   // phase clocks and channel run enables
   output logic                              ch1Clock,
   output logic                              ch2Clock,
   output logic                              ch1Run,
   output logic                              ch2Run,
   // sync out pin, two signals
   output logic                              syncOut,
   output logic                              syncOutEn
);
   //------------------------------------------------------------
   // strap capture
   //------------------------------------------------------------
   logic [7:0]    strapNow;
   logic [7:0]    strapPrev_r;
   logic [3:0]    settleCnt_r;
   logic          modeValid_r;
   mode_type      mode_r;
   mode_type      modeNxt;
   logic [8:0]    phaseCnt_r;
   logic          phaseRun_r;
   logic [8:0]    ch2Phase;
   logic [8:0]    syncPhase;
   logic          syncOn;
   logic [8:0]    ch2Pos;
   logic [8:0]    syncPos;

   assign strapNow = {ch1EnableFeedforward, ch2EnableFeedforward,
                      ch2NegSenseStrap, ch2FeedbackStrap,
                      ch2PosSenseStrap, refLevel, ch1NegSenseStrap};

   // settle counter; any strap change restarts it
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         strapPrev_r <= 8'h00;
         settleCnt_r <= 4'h0;
      end else begin
         strapPrev_r <= strapNow;
         if (strapNow != strapPrev_r) begin
            settleCnt_r <= 4'h0;
         end else if (settleCnt_r != STRAP_SETTLE) begin
            settleCnt_r <= settleCnt_r + 4'h1;
         end
      end
   end

   //------------------------------------------------------------
   // mode decode
   //------------------------------------------------------------
   always_comb begin
      modeNxt = M_DISABLED;
      if (!ch1EnableFeedforward && !ch2EnableFeedforward) begin
         modeNxt = M_DISABLED; // R2
      end else if (ch1EnableFeedforward != ch2EnableFeedforward) begin
         modeNxt = M_SINGLE; // R3
      end else if (ch2NegSenseStrap) begin
         if (!ch2FeedbackStrap) begin
            modeNxt = M_TWO_PHASE; // R7
         end else if (!ch2PosSenseStrap) begin
            modeNxt = M_THREE_PHASE; // R9
         end else begin
            modeNxt = M_FOUR_PHASE; // R11
         end
      end else begin
         unique case (refLevel) // R4
            REF_LOW:    modeNxt = M_DDR;
            REF_MID_LO: modeNxt = M_DUAL_0;
            REF_MID_HI: modeNxt = M_DUAL_90;
            REF_HIGH:   modeNxt = M_DUAL_180;
         endcase
      end
   end

   // latch mode once straps settle, before switching starts
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_r      <= M_DISABLED;
         modeValid_r <= 1'b0;
      end else if (strapNow != strapPrev_r) begin
         modeValid_r <= 1'b0; // R16
      end else if (settleCnt_r == STRAP_SETTLE) begin
         mode_r      <= modeNxt; // R16
         modeValid_r <= 1'b1;
      end
   end

   //------------------------------------------------------------
   // phase table
   //------------------------------------------------------------
   always_comb begin
      ch2Phase  = PH_0;
      syncPhase = PH_0;
      syncOn    = 1'b0;
      unique case (mode_r)
         M_DISABLED, M_SINGLE: ch2Phase = PH_0;
         M_DUAL_0:      ch2Phase = PH_0; // R4
         M_DUAL_90:     ch2Phase = PH_90; // R4
         M_DUAL_180:    ch2Phase = PH_180; // R4
         M_DDR:         ch2Phase = PH_300; // R6
         M_TWO_PHASE: begin
            ch2Phase  = PH_180; // R7
            syncPhase = PH_60; // R8
            syncOn    = 1'b1; // R13
         end
         M_THREE_PHASE: begin
            ch2Phase  = PH_240; // R9
            syncPhase = PH_120; // R10
            syncOn    = 1'b1;
         end
         M_FOUR_PHASE: begin
            ch2Phase  = PH_180; // R11
            syncPhase = PH_90; // R11
            syncOn    = 1'b1; // R12
         end
      endcase
   end

   // one common oscillator cycle counter
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phaseCnt_r <= 9'h000;
      end else if (phaseCnt_r == CYCLE_STEPS - 9'h001) begin
         phaseCnt_r <= 9'h000; // R16
      end else begin
         phaseCnt_r <= phaseCnt_r + 9'h001;
      end
   end

   // switching starts only at a cycle boundary, so no runt first ch1 pulse; ch2 at 240 or 300 deg starts mid-pulse
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         phaseRun_r <= 1'b0;
      end else if (!modeValid_r) begin
         phaseRun_r <= 1'b0; // R16
      end else if (phaseCnt_r == CYCLE_STEPS - 9'h001) begin
         phaseRun_r <= 1'b1; // R16
      end
   end

   // position relative to each shifted start, modulo the cycle
   function automatic logic [8:0] relPos(input logic [8:0] cnt,
                                         input logic [8:0] ofs);
      logic [9:0] d;
      d = {1'b0, cnt} + {1'b0, CYCLE_STEPS} - {1'b0, ofs};
      if (d >= {1'b0, CYCLE_STEPS}) begin
         d = d - {1'b0, CYCLE_STEPS};
      end
      return d[8:0];
   endfunction

   assign ch2Pos  = relPos(phaseCnt_r, ch2Phase);
   assign syncPos = relPos(phaseCnt_r, syncPhase);

   //------------------------------------------------------------
   // registered outputs
   //------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ch1Clock  <= 1'b0;
         ch2Clock  <= 1'b0;
         syncOut   <= 1'b0;
         syncOutEn <= 1'b0;
      end else begin
         // each clock high for the first half of its own cycle
         ch1Clock  <= modeValid_r && phaseRun_r && (phaseCnt_r < PH_180);
         ch2Clock  <= modeValid_r && phaseRun_r && (ch2Pos < PH_180);
         syncOut   <= modeValid_r && phaseRun_r && syncOn && // R8
                      (syncPos < PH_180);
         syncOutEn <= modeValid_r && syncOn; // R15
      end
   end

   // channel run, amplifier and reference controls
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ch1Run       <= 1'b0;
         ch2Run       <= 1'b0;
         ch1AmpEnable <= 1'b0;
         ch2AmpEnable <= 1'b0;
         shareCh1Only <= 1'b0;
         ch2RefSelect <= 2'h0;
      end else begin
         ch1Run <= modeValid_r && mode_r != M_DISABLED && // R2
                   (mode_r != M_SINGLE || ch1EnableFeedforward);
         ch2Run <= modeValid_r && mode_r != M_DISABLED &&
                   (mode_r != M_SINGLE || ch2EnableFeedforward);
         ch1AmpEnable <= !ch1NegSenseStrap; // R1
         ch2AmpEnable <= !ch2NegSenseStrap; // R1
         shareCh1Only <= mode_r == M_SINGLE || mode_r == M_DDR || // R3
                         mode_r == M_DUAL_0 || mode_r == M_DUAL_90 ||
                         mode_r == M_DUAL_180;
         // 0 internal, 1 external pin, 2 soft-start
         if (mode_r != M_DDR) begin
            ch2RefSelect <= softStartBelowInt ? 2'h2 : 2'h0;
         end else if (softStartBelowInt && softStartBelowExt) begin
            ch2RefSelect <= 2'h2; // R5
         end else if (extRefBelowInt) begin
            ch2RefSelect <= 2'h1; // R5
         end else begin
            ch2RefSelect <= 2'h0; // R5
         end
      end
   end

   assign modeValid = modeValid_r;
   assign mode      = mode_r;
endmodule
`default_nettype wire

// >>> tb/dual_pwm_mode_phase_select_props.sv
// checker for the mode and phase outputs of the selector
// sees only the top module ports; bound below the module
`timescale 1ns/1ps
`default_nettype none
module dual_pwm_mode_phase_select_props
   import pwm_mode_pkg::*;
(
   // clock, reset and straps
   input wire logic                    clk_sys,
   input wire logic                    sys_rst,
   input wire logic                    ch1NegSenseStrap,
   input wire logic                    ch2NegSenseStrap,
   // decoded outputs
   input wire logic                    modeValid,
   input wire pwm_mode_pkg::mode_type  mode,
   input wire logic                    ch1AmpEnable,
   input wire logic                    shareCh1Only,
   input wire logic                    ch1Clock,
   input wire logic                    ch2Clock,
   input wire logic                    ch1Run,
   input wire logic                    ch2Run,
   input wire logic                    syncOut,
   input wire logic                    syncOutEn
);
   logic [8:0] hiCnt_r;
   logic       validLost_r;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // count high cycles of the channel 1 clock
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         hiCnt_r <= 9'h000;
      end else if (ch1Clock) begin
         hiCnt_r <= hiCnt_r + 9'h001;
      end else begin
         hiCnt_r <= 9'h000;
      end
   end
   // remembers a loss of modeValid since the last ch1 clock rise
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         validLost_r <= 1'b0;
      end else if (!modeValid) begin
         validLost_r <= 1'b1;
      end else if (ch1Clock && hiCnt_r == 9'h000) begin
         validLost_r <= 1'b0;
      end
   end
   a_amp_off_strap: assert property (ch1NegSenseStrap |=> !ch1AmpEnable)
      else $error("amp on with strap near supply");
   a_disabled_idle: assert property (modeValid && mode == M_DISABLED |=>
      !ch1Run && !ch2Run) else $error("switching while disabled");
   a_single_share: assert property (modeValid && mode == M_SINGLE
      ##1 modeValid |-> shareCh1Only) else $error("share not ch1");
   a_sync_off_dual: assert property (modeValid && mode inside
      {[M_DUAL_0:M_DDR]} |-> !syncOutEn) else $error("sync in dual");
   a_two_phase: assert property ($rose(ch1Clock) && mode == M_TWO_PHASE
      |-> ##180 ($rose(ch2Clock) || !modeValid || validLost_r))
      else $error("2ph skew");
   a_ddr_lead: assert property ($rose(ch1Clock) && mode == M_DDR
      |-> ##300 ($rose(ch2Clock) || !modeValid || validLost_r))
      else $error("ddr skew");
   a_four_sync: assert property ($rose(ch1Clock) && mode == M_FOUR_PHASE
      |-> ##90 ($rose(syncOut) || !modeValid || validLost_r))
      else $error("4ph sync");
   a_half_period: assert property ($fell(ch1Clock) && modeValid &&
      $past(modeValid) |-> hiCnt_r == 9'h0b4) else $error("bad duty");
   a_strap_restart: assert property ($changed(ch2NegSenseStrap)
      |-> ##[1:2] !modeValid) else $error("strap change kept valid");
endmodule
bind dual_pwm_mode_phase_select dual_pwm_mode_phase_select_props
   i_dual_pwm_mode_phase_select_props (
      .clk_sys          (clk_sys),
      .sys_rst          (sys_rst),
      .ch1NegSenseStrap (ch1NegSenseStrap),
      .ch2NegSenseStrap (ch2NegSenseStrap),
      .modeValid        (modeValid),
      .mode             (mode),
      .ch1AmpEnable     (ch1AmpEnable),
      .shareCh1Only     (shareCh1Only),
      .ch1Clock         (ch1Clock),
      .ch2Clock         (ch2Clock),
      .ch1Run           (ch1Run),
      .ch2Run           (ch2Run),
      .syncOut          (syncOut),
      .syncOutEn        (syncOutEn)
   );
`default_nettype wire

// >>> tb/cascade_follower.sv
// follower controller that locks its channel 1 to the sync pin
// assumes the pin is pulled low while the sender releases it
`timescale 1ns/1ps
`default_nettype none
module cascade_follower (
   // clock and reset
   input wire logic  clk_sys,
   input wire logic  sys_rst,
   // sync pin level and own channel clock
   input wire logic  syncPin,
   output logic      followClock
);
   logic       syncPin_r;
   logic [8:0] cnt_r;
   // restart own cycle on each sync rise; runs as two or four phase
   // other phase counts would need an outside clock, not this pin
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         syncPin_r <= 1'b0;
         cnt_r <= 9'h168;
      end else begin
         syncPin_r <= syncPin;
         if (syncPin && !syncPin_r) cnt_r <= 9'h000;
         else if (cnt_r != 9'h168) cnt_r <= cnt_r + 9'h001;
      end
   end
   assign followClock = cnt_r < 9'h0b4;
endmodule
`default_nettype wire

// >>> tb/tb_dual_pwm_mode_phase_select.sv
// bench: strap rows with expected mode, phases and sync clock
// assumes follower model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_dual_pwm_mode_phase_select;
   import pwm_mode_pkg::*;
   logic clk_sys, sys_rst, ch1EnableFeedforward, ch2EnableFeedforward;
   logic ch1NegSenseStrap, ch2NegSenseStrap, ch2FeedbackStrap;
   logic ch2PosSenseStrap, extRefBelowInt, softStartBelowExt;
   logic softStartBelowInt, modeValid, ch1AmpEnable, ch2AmpEnable;
   logic shareCh1Only, ch1Clock, ch2Clock, ch1Run, ch2Run, syncOut;
   logic syncOutEn, syncPin, followClock;
   logic [1:0] ch2RefSelect;
   ref_level_type refLevel;
   mode_type mode;
   int n_fail, samples_checked;
   dual_pwm_mode_phase_select i_dual_pwm_mode_phase_select (
      .clk_sys              (clk_sys),
      .sys_rst              (sys_rst),
      .ch1EnableFeedforward (ch1EnableFeedforward),
      .ch2EnableFeedforward (ch2EnableFeedforward),
      .ch1NegSenseStrap     (ch1NegSenseStrap),
      .ch2NegSenseStrap     (ch2NegSenseStrap),
      .ch2FeedbackStrap     (ch2FeedbackStrap),
      .ch2PosSenseStrap     (ch2PosSenseStrap),
      .refLevel             (refLevel),
      .extRefBelowInt       (extRefBelowInt),
      .softStartBelowExt    (softStartBelowExt),
      .softStartBelowInt    (softStartBelowInt),
      .modeValid            (modeValid),
      .mode                 (mode),
      .ch1AmpEnable         (ch1AmpEnable),
      .ch2AmpEnable         (ch2AmpEnable),
      .shareCh1Only         (shareCh1Only),
      .ch2RefSelect         (ch2RefSelect),
      .ch1Clock             (ch1Clock),
      .ch2Clock             (ch2Clock),
      .ch1Run               (ch1Run),
      .ch2Run               (ch2Run),
      .syncOut              (syncOut),
      .syncOutEn            (syncOutEn)
   );
   cascade_follower i_cascade_follower (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .syncPin     (syncPin),
      .followClock (followClock)
   );
   assign syncPin = syncOutEn ? syncOut : 1'b0; // pull-down when released
   // ----
   // tasks
   // ----
   task automatic summarize();
      $display("checks %0d failures %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic row(input logic [4:0] s, input ref_level_type r,
      input mode_type m, input logic [8:0] e2, input logic [8:0] eF);
      logic [8:0] d2, dF;
      logic p1, p2, pF;
      int n;
      @(posedge clk_sys);
      {ch1EnableFeedforward, ch2EnableFeedforward, ch2NegSenseStrap,
         ch2FeedbackStrap, ch2PosSenseStrap} <= s;
      ch1NegSenseStrap <= s[2];
      refLevel <= r;
      repeat (3) @(negedge clk_sys);
      for (n = 0; modeValid !== 1'b1 && n < 40; n++) @(negedge clk_sys);
      if (n >= 40) begin n_fail++; summarize(); end
      repeat (2) @(negedge clk_sys);
      chk("mode", 9'(m), 9'(mode));
      chk("amp1", 9'(!s[2]), 9'(ch1AmpEnable));
      chk("amp2", 9'(!s[2]), 9'(ch2AmpEnable));
      chk("share", 9'(m inside {[M_SINGLE:M_DDR]}), 9'(shareCh1Only));
      chk("syncEn", 9'(m > M_DDR), 9'(syncOutEn));
      chk("run", 9'((m <= M_SINGLE) ? s[4:3] : 2'h3),
         9'({ch1Run, ch2Run}));
      if (m <= M_SINGLE) begin
         return;
      end
      d2 = 9'h1ff;
      dF = 9'h1ff;
      // let switching start at a cycle boundary and settle one cycle
      repeat (360) @(negedge clk_sys);
      n = 0;
      do begin
         {p1, p2, pF} = {ch1Clock, ch2Clock, followClock};
         @(negedge clk_sys);
         n++;
      end while (!(p1 === 1'b0 && ch1Clock === 1'b1) && n < 800);
      if (n >= 800) begin n_fail++; summarize(); end
      for (int k = 0; k < 360; k++) begin
         if (!p2 && ch2Clock === 1'b1 && d2 === 9'h1ff) d2 = 9'(k);
         if (!pF && followClock === 1'b1 && dF === 9'h1ff) dF = 9'(k);
         {p2, pF} = {ch2Clock, followClock};
         @(negedge clk_sys);
      end
      chk("ch2Phase", e2, d2);
      chk("syncPhase", eF, dF);
   endtask
   // ----
   // clock and main sequence
   // ----
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      {ch1EnableFeedforward, ch2EnableFeedforward, ch1NegSenseStrap} = '0;
      {ch2NegSenseStrap, ch2FeedbackStrap, ch2PosSenseStrap} = '0;
      {extRefBelowInt, softStartBelowExt, softStartBelowInt} = '0;
      {n_fail, samples_checked} = '0;
      refLevel = REF_LOW;
      sys_rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      row(5'b00000, REF_LOW, M_DISABLED, 9'h1ff, 9'h1ff);
      row(5'b10000, REF_LOW, M_SINGLE, 9'h1ff, 9'h1ff);
      row(5'b01000, REF_LOW, M_SINGLE, 9'h1ff, 9'h1ff);
      row(5'b11000, REF_MID_LO, M_DUAL_0, 9'h000, 9'h1ff);
      row(5'b11000, REF_MID_HI, M_DUAL_90, 9'h05a, 9'h1ff);
      row(5'b11000, REF_HIGH, M_DUAL_180, 9'h0b4, 9'h1ff);
      row(5'b11000, REF_LOW, M_DDR, 9'h12c, 9'h1ff);
      // lowest of internal, external and soft-start; one cycle registered
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         {extRefBelowInt, softStartBelowExt, softStartBelowInt} <=
            (i == 0) ? 3'h4 : (i == 1) ? 3'h7 : 3'h0;
         repeat (3) @(negedge clk_sys);
         chk("refSel", (i == 0) ? 9'h001 : (i == 1) ? 9'h002 : 9'h000,
            9'(ch2RefSelect));
      end
      row(5'b11100, REF_LOW, M_TWO_PHASE, 9'h0b4, 9'h03d);
      row(5'b11110, REF_LOW, M_THREE_PHASE, 9'h0f0, 9'h079);
      row(5'b11111, REF_LOW, M_FOUR_PHASE, 9'h0b4, 9'h05b);
      summarize();
   end
endmodule
`default_nettype wire
